// [inc/phy_cfg_regs_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the PHY config bank.
// Assumes: Registers are one aligned 32-bit word each on classic Wishbone.
// Notes: Offsets 0x31, 0x33, 0x43, 0x55 are not multiples of four, so byte address = 4 * index.
`ifndef PHY_CFG_REGS_CFG_SVH
`define PHY_CFG_REGS_CFG_SVH
`define IDX_CONFIG_FOUR 8'h31
`define IDX_RGMII_CONTROL 8'h32
`define IDX_RGMII_CONTROL_TWO 8'h33
`define IDX_FAST_ETHERNET_CONFIG 8'h43
`define IDX_CHANNEL_SKEW_STATUS 8'h55
`define RST_CONFIG_FOUR 16'h0010
`define RST_RGMII_CONTROL 16'h00D0
`define RST_RGMII_CONTROL_TWO 16'h0000
`define RST_FAST_ETHERNET_CONFIG 16'h07A0
`define WMASK_CONFIG_FOUR 16'h0181
`define WMASK_RGMII_CONTROL 16'h00FB
`define WMASK_RGMII_CONTROL_TWO 16'h0010
`define WMASK_FAST_ETHERNET_CONFIG 16'h0FFF
`define CLK_HZ 50000000
`define DESCRAMBLER_RECOVERY_TIME_US 1500
`define DESCRAMBLER_RECOVERY_TIME_CYC ((`DESCRAMBLER_RECOVERY_TIME_US * (`CLK_HZ / 1000000)))
`define MS_US 1000
`define MS_CYC ((`MS_US * (`CLK_HZ / 1000000)))
`endif

// [inc/phy_cfg_regs_pkg.sv]
// Purpose: Types of the PHY config bank.
// Assumes: Nothing beyond the cfg header.
// Notes: Receive state of the 100BASE-TX supervisor.
package phy_cfg_regs_pkg;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_FRAME = 3'h2,
    RX_RECOVER = 3'h4
  } rx_state_t;
endpackage

// [hw/phy_rgmii_100tx_config_regs.sv]
// Purpose: Wishbone register bank driving RGMII and 100BASE-TX receive options.
// Assumes: Single clock, synchronous active-high reset, frame and unlock pins asynchronous.
// Notes: Register byte address is four times the printed index.
//
// Design decision made here: register access over Wishbone.
`include "phy_cfg_regs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1: Config bit 0 enables port mirroring
// R2: RGMII control bit 7 enables RGMII, default 1
// R3: Bits 6:5 set receive FIFO threshold
// R4: Bits 4:3 set transmit FIFO threshold
// R5: Reserved RGMII bits ignore writes, read zero
// R6: Bit 1 shifts transmit clock
// R7: Bit 0 shifts receive clock
// R8: Control two bit 4 bypasses async FIFO
// R9: Frames beyond 1.5 ms are cut off
// R10: Bits 10:7 set recovery time in ms
// R11: Bit 6 forces good 100 Mbps link
// R12: Bit 5 enables enhanced ternary detection
// R13: Bit 4 enables enhanced gap detection
// R14: Bit 3 skips 4B/5B receive decoder
// R15: Bit 2 turns scrambler off
// R16: Bit 1 enables odd nibble detection
// R17: Bit 0 enables early receive valid
// R18: Skew bits 7:4 report channel B
// R19: Skew bits 3:0 report channel A
// R20: Read-only reserved fields keep their defaults
module phy_rgmii_100tx_config_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Datapath status
  input wire logic rx_frame_i,
  input wire logic descram_unlock_i,
  input wire logic [3:0] channel_a_offset_i,
  input wire logic [3:0] channel_b_offset_i,
  // Datapath controls
  output logic port_mirror_o,
  output logic rgmii_enable_o,
  output logic [1:0] rx_fifo_half_threshold_o,
  output logic [1:0] tx_fifo_half_threshold_o,
  output logic tx_clock_shift_o,
  output logic rx_clock_shift_o,
  output logic async_fifo_skip_o,
  output logic force_link_good_o,
  output logic enhanced_ternary_detect_o,
  output logic enhanced_gap_detect_o,
  output logic rx_decoder_skip_o,
  output logic scrambler_off_o,
  output logic odd_nibble_detect_o,
  output logic early_receive_valid_o,
  output logic rx_allow_o,
  output phy_cfg_regs_pkg::rx_state_t rx_state_o
);
  import phy_cfg_regs_pkg::*;

  localparam int unsigned TIMEOUT_CYC = `DESCRAMBLER_RECOVERY_TIME_CYC;
  localparam int unsigned MS_CYC = `MS_CYC;

  logic [15:0] config_four_q;
  logic [15:0] rgmii_control_q;
  logic [15:0] rgmii_control_two_q;
  logic [15:0] fast_ethernet_config_q;
  logic [7:0] skew_q;
  logic [2:0] frame_sync_q;
  logic [1:0] unlock_sync_q;
  logic [16:0] cycle_cnt_q;
  logic [15:0] ms_cnt_q;
  logic [3:0] ms_left_q;
  rx_state_t state_q;
  logic [7:0] idx;
  logic bus_req;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wdata;
  logic [15:0] rdata;

  assign idx = adr_i[9:2];
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_lo = bus_req && we_i && sel_i[0];
  assign wr_hi = bus_req && we_i && sel_i[1];

  // Merge write data into the old value per byte lane and keep only writable bits.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] nv;
    nv = old;
    if (wr_lo) begin
      nv[7:0] = wdata[7:0];
    end
    if (wr_hi) begin
      nv[15:8] = wdata[15:8];
    end
    merge = (nv & mask) | (old & ~mask);
  endfunction

  assign wdata = dat_i[15:0];

  // Ack comes one cycle after the request and drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_four_q <= `RST_CONFIG_FOUR;
    end else if (idx == `IDX_CONFIG_FOUR) begin
      config_four_q <= merge(config_four_q, `WMASK_CONFIG_FOUR); // R1 R20
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rgmii_control_q <= `RST_RGMII_CONTROL;
    end else if (idx == `IDX_RGMII_CONTROL) begin
      rgmii_control_q <= merge(rgmii_control_q, `WMASK_RGMII_CONTROL); // R2 R3 R4 R5 R6 R7
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rgmii_control_two_q <= `RST_RGMII_CONTROL_TWO;
    end else if (idx == `IDX_RGMII_CONTROL_TWO) begin
      rgmii_control_two_q <= merge(rgmii_control_two_q, `WMASK_RGMII_CONTROL_TWO); // R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_ethernet_config_q <= `RST_FAST_ETHERNET_CONFIG;
    end else if (idx == `IDX_FAST_ETHERNET_CONFIG) begin
      // R9 R10 R11 R12 R13 R14 R15 R16 R17
      fast_ethernet_config_q <= merge(fast_ethernet_config_q, `WMASK_FAST_ETHERNET_CONFIG);
    end
  end

  // Skew counts come from another domain; a two-stage sample only limits
  // metastability, so a multi-bit change may read torn for one cycle.
  logic [7:0] skew_meta_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skew_meta_q <= 8'h00;
      skew_q <= 8'h00;
    end else begin
      skew_meta_q <= {channel_b_offset_i, channel_a_offset_i};
      skew_q <= skew_meta_q; // R18 R19
    end
  end

  always_comb begin
    case (idx)
      `IDX_CONFIG_FOUR: rdata = config_four_q;
      `IDX_RGMII_CONTROL: rdata = rgmii_control_q & `WMASK_RGMII_CONTROL; // R5
      `IDX_RGMII_CONTROL_TWO: rdata = rgmii_control_two_q;
      `IDX_FAST_ETHERNET_CONFIG: rdata = fast_ethernet_config_q;
      `IDX_CHANNEL_SKEW_STATUS: rdata = {8'h00, skew_q}; // R18 R19
      default: rdata = 16'h0000;
    endcase
  end

  // Read data is registered with the ack; unmapped indices read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (bus_req && !we_i) begin
      dat_o <= {16'h0000, rdata};
    end
  end

  assign port_mirror_o = config_four_q[0]; // R1
  assign rgmii_enable_o = rgmii_control_q[7]; // R2
  assign rx_fifo_half_threshold_o = rgmii_control_q[6:5]; // R3
  assign tx_fifo_half_threshold_o = rgmii_control_q[4:3]; // R4
  assign tx_clock_shift_o = rgmii_control_q[1]; // R6
  assign rx_clock_shift_o = rgmii_control_q[0]; // R7
  assign async_fifo_skip_o = rgmii_control_two_q[4]; // R8
  assign force_link_good_o = fast_ethernet_config_q[6]; // R11
  assign enhanced_ternary_detect_o = fast_ethernet_config_q[5]; // R12
  assign enhanced_gap_detect_o = fast_ethernet_config_q[4]; // R13
  assign rx_decoder_skip_o = fast_ethernet_config_q[3]; // R14
  assign scrambler_off_o = fast_ethernet_config_q[2]; // R15
  assign odd_nibble_detect_o = fast_ethernet_config_q[1]; // R16
  assign early_receive_valid_o = fast_ethernet_config_q[0]; // R17

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_sync_q <= 3'h0;
      unlock_sync_q <= 2'h0;
    end else begin
      frame_sync_q <= {frame_sync_q[1:0], rx_frame_i};
      unlock_sync_q <= {unlock_sync_q[0], descram_unlock_i};
    end
  end

  // Timeout supervisor: a frame longer than 1.5 ms is cut off. With the disable
  // bit set the same overrun drops reception too, as the bit is described;
  // both settings therefore act alike here. Unlock in idle starts the ms recovery.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= RX_IDLE;
      cycle_cnt_q <= 17'h00000;
      ms_cnt_q <= 16'h0000;
      ms_left_q <= 4'h0;
    end else begin
      case (state_q)
        RX_IDLE: begin
          cycle_cnt_q <= 17'h00000;
          if (unlock_sync_q[1]) begin
            state_q <= RX_RECOVER;
            ms_cnt_q <= 16'h0000;
            ms_left_q <= fast_ethernet_config_q[10:7]; // R10
          end else if (frame_sync_q[1] && !frame_sync_q[2]) begin
            state_q <= RX_FRAME;
          end
        end
        RX_FRAME: begin
          cycle_cnt_q <= cycle_cnt_q + 17'h00001;
          if (!frame_sync_q[2]) begin
            state_q <= RX_IDLE;
          end else if (cycle_cnt_q == 17'(TIMEOUT_CYC - 1)) begin
            state_q <= RX_RECOVER; // R9
            ms_cnt_q <= 16'h0000;
            ms_left_q <= fast_ethernet_config_q[10:7]; // R10
          end
        end
        RX_RECOVER: begin
          if (ms_left_q == 4'h0) begin
            if (!frame_sync_q[2] && !unlock_sync_q[1]) begin
              state_q <= RX_IDLE;
            end
          end else if (ms_cnt_q == 16'(MS_CYC - 1)) begin
            ms_cnt_q <= 16'h0000;
            ms_left_q <= ms_left_q - 4'h1; // R10
          end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end

  assign rx_allow_o = (state_q != RX_RECOVER) && rgmii_control_q[7]; // R9 R2
  assign rx_state_o = state_q;

  AST_MIRROR: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (ack_o && $past(we_i) && $past(sel_i[0]) && $past(idx) == `IDX_CONFIG_FOUR)
    |-> port_mirror_o == $past(dat_i[0]))
    else $error("Mirror bit did not follow write.");
  AST_RGMII_EN: assert property (@(posedge clk_i) $fell(rst_i) |-> rgmii_enable_o) // R2
    else $error("RGMII enable not set after reset.");
  AST_THRESH: assert property (@(posedge clk_i) $fell(rst_i) // R3 R4
    |-> rx_fifo_half_threshold_o == 2'h2 && tx_fifo_half_threshold_o == 2'h2)
    else $error("FIFO threshold defaults wrong.");
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (ack_o && !$past(we_i) && $past(idx) == `IDX_RGMII_CONTROL)
    |-> dat_o[15:8] == 8'h00 && dat_o[2] == 1'b0)
    else $error("Reserved RGMII bits read nonzero.");
  AST_BYPASS: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (ack_o && $past(we_i) && $past(sel_i[0]) && $past(idx) == `IDX_RGMII_CONTROL_TWO)
    |-> async_fifo_skip_o == $past(dat_i[4]))
    else $error("Async FIFO skip did not follow write.");
  AST_TIMEOUT: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (state_q == RX_FRAME && frame_sync_q[2] && cycle_cnt_q == 17'(TIMEOUT_CYC - 1))
    |=> !rx_allow_o)
    else $error("Overlong frame not cut off.");
  AST_RECOVER_LOAD: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (state_q != RX_RECOVER) ##1 (state_q == RX_RECOVER)
    |-> ms_left_q == $past(fast_ethernet_config_q[10:7]))
    else $error("Recovery time not loaded from field.");
  AST_TX_DEFAULT: assert property (@(posedge clk_i) $fell(rst_i) // R12 R11
    |-> enhanced_ternary_detect_o && !force_link_good_o && !scrambler_off_o)
    else $error("100BASE-TX defaults wrong.");
  AST_SKEW: assert property (@(posedge clk_i) disable iff (rst_i) // R18 R19
    (ack_o && !$past(we_i) && $past(idx) == `IDX_CHANNEL_SKEW_STATUS)
    |-> dat_o[15:0] == {8'h00, $past(skew_q)})
    else $error("Skew readback wrong.");
  AST_CONFIG_FOUR_RO: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    config_four_q[6:1] == 6'h08 && config_four_q[15:9] == 7'h00)
    else $error("Read-only config bits changed.");

  // Bus handshake checks: a taken request is answered once, one cycle later.
  // A second ack in a row would make the master retire two transfers for one.
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Ack stood for more than one cycle.");
  AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> ack_o)
    else $error("Taken request was not acknowledged.");

  // Read-only and reserved storage ignores software writes; skew status only follows its sync stage.
  AST_RGMII_RO: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    rgmii_control_q[15:8] == 8'h00 && !rgmii_control_q[2])
    else $error("Reserved RGMII storage changed.");
  AST_RGMII2_RO: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    (rgmii_control_two_q & ~`WMASK_RGMII_CONTROL_TWO) == 16'h0000)
    else $error("Reserved second RGMII bits changed.");
  AST_FAST_RO: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    fast_ethernet_config_q[15:12] == 4'h0)
    else $error("Reserved 100BASE-TX bits changed.");
  AST_SKEW_SYNC: assert property (@(posedge clk_i) disable iff (rst_i) // R18 R19
    skew_q == $past(skew_meta_q))
    else $error("Skew status skipped a sync stage.");

  // Supervisor checks. The state is kept one-hot so a glitch shows at once.
  AST_ONE_HOT: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(state_q))
    else $error("Receive state not one-hot.");
  AST_FRAME_START: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (state_q == RX_IDLE && !unlock_sync_q[1] && frame_sync_q[1] && !frame_sync_q[2])
    |=> state_q == RX_FRAME)
    else $error("Frame start not seen.");
  AST_RECOVER_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    state_q == RX_RECOVER |-> !rx_allow_o)
    else $error("Reception allowed during recovery.");
  AST_RGMII_GATE: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    !rgmii_enable_o |-> !rx_allow_o)
    else $error("Reception allowed with RGMII disabled.");
  AST_MS_TICK: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (state_q == RX_RECOVER && ms_left_q != 4'h0 && ms_cnt_q == 16'(MS_CYC - 1))
    |=> ms_left_q == $past(ms_left_q) - 4'h1)
    else $error("Recovery millisecond not counted.");
  AST_RECOVER_EXIT: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (state_q == RX_RECOVER && ms_left_q == 4'h0 && !frame_sync_q[2] && !unlock_sync_q[1])
    |=> state_q == RX_IDLE)
    else $error("Recovery did not end.");
  AST_UNLOCK_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (state_q == RX_IDLE && unlock_sync_q[1]) |=> state_q == RX_RECOVER)
    else $error("Unlock did not start recovery.");
endmodule
`default_nettype wire

// [bench/mac_link_model.sv]
// Purpose: Far-side receive status seen by the config bank.
// Assumes: Frame and unlock move only through their tasks.
// Notes: Offsets change only through set_skew, between bus cycles.
`timescale 1ns/10ps
`default_nettype none
module mac_link_model (
  // Clock
  input wire logic clk_i,
  // Status towards the bank
  output logic rx_frame_o,
  output logic descram_unlock_o,
  output logic [3:0] channel_a_offset_o,
  output logic [3:0] channel_b_offset_o
);
  initial begin
    rx_frame_o = 1'b0;
    descram_unlock_o = 1'b0;
    channel_a_offset_o = 4'h0;
    channel_b_offset_o = 4'h0;
  end
  // Stepped just after an edge so the synchronisers see one clean change.
  task automatic set_skew(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk_i);
    channel_a_offset_o <= a;
    channel_b_offset_o <= b;
  endtask
  task automatic set_frame(input logic v);
    @(posedge clk_i);
    rx_frame_o <= v;
  endtask
  task automatic set_unlock(input logic v);
    @(posedge clk_i);
    descram_unlock_o <= v;
  endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the PHY config bank.
// Assumes: Ack one cycle after the request is taken.
// Notes: Slot 5 is an unmapped index that must read zero.
`include "phy_cfg_regs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import phy_cfg_regs_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, rx_frame, unlock, rx_allow_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i, off_a, off_b;
  logic [31:0] dat_i, dat_o;
  logic port_mirror_o, rgmii_enable_o, tx_clock_shift_o, rx_clock_shift_o;
  logic [1:0] rx_fifo_half_threshold_o, tx_fifo_half_threshold_o;
  logic async_fifo_skip_o, force_link_good_o, enhanced_ternary_detect_o;
  logic enhanced_gap_detect_o, rx_decoder_skip_o, scrambler_off_o;
  logic odd_nibble_detect_o, early_receive_valid_o;
  rx_state_t rx_state_o;
  logic [7:0] idx [6] = '{`IDX_CONFIG_FOUR, `IDX_RGMII_CONTROL, `IDX_RGMII_CONTROL_TWO,
    `IDX_FAST_ETHERNET_CONFIG, `IDX_CHANNEL_SKEW_STATUS, 8'h34};
  logic [15:0] wm [6] = '{`WMASK_CONFIG_FOUR, `WMASK_RGMII_CONTROL,
    `WMASK_RGMII_CONTROL_TWO, `WMASK_FAST_ETHERNET_CONFIG, 16'h0000, 16'h0000};
  logic [15:0] m [6];
  logic [31:0] expq [$];
  int miscompares = 0;
  int n_checks = 0;

  phy_rgmii_100tx_config_regs phy_rgmii_100tx_config_regs_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_frame_i(rx_frame), .descram_unlock_i(unlock),
    .channel_a_offset_i(off_a), .channel_b_offset_i(off_b), .port_mirror_o(port_mirror_o),
    .rgmii_enable_o(rgmii_enable_o), .rx_fifo_half_threshold_o(rx_fifo_half_threshold_o),
    .tx_fifo_half_threshold_o(tx_fifo_half_threshold_o), .tx_clock_shift_o(tx_clock_shift_o),
    .rx_clock_shift_o(rx_clock_shift_o), .async_fifo_skip_o(async_fifo_skip_o),
    .force_link_good_o(force_link_good_o), .enhanced_ternary_detect_o(enhanced_ternary_detect_o),
    .enhanced_gap_detect_o(enhanced_gap_detect_o), .rx_decoder_skip_o(rx_decoder_skip_o),
    .scrambler_off_o(scrambler_off_o), .odd_nibble_detect_o(odd_nibble_detect_o),
    .early_receive_valid_o(early_receive_valid_o), .rx_allow_o(rx_allow_o),
    .rx_state_o(rx_state_o));
  mac_link_model mac_link_model_i (.clk_i(clk_i), .rx_frame_o(rx_frame),
    .descram_unlock_o(unlock), .channel_a_offset_o(off_a), .channel_b_offset_o(off_b));

  task automatic fail(input string s);
    miscompares++;
    $display("MISMATCH t=%0t %s", $time, s);
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check_dat(input logic [31:0] e);
    n_checks++;
    if (dat_o !== e) fail($sformatf("read %h exp %h", dat_o, e));
  endtask
  task automatic check_ports;
    logic [15:0] e, a;
    e = {m[0][0], m[1][7], m[1][6:5], m[1][4:3], m[1][1], m[1][0], m[2][4], m[3][6:0]};
    a = {port_mirror_o, rgmii_enable_o, rx_fifo_half_threshold_o, tx_fifo_half_threshold_o,
      tx_clock_shift_o, rx_clock_shift_o, async_fifo_skip_o, force_link_good_o,
      enhanced_ternary_detect_o, enhanced_gap_detect_o, rx_decoder_skip_o, scrambler_off_o,
      odd_nibble_detect_o, early_receive_valid_o};
    n_checks++;
    if (a !== e) fail($sformatf("controls %h exp %h", a, e));
    n_checks++;
    if ({rx_allow_o, rx_state_o} !== {m[1][7], RX_IDLE}) fail("receive gate");
  endtask
  task automatic check_state(input rx_state_t e, input logic g);
    n_checks++;
    if ({rx_allow_o, rx_state_o} !== {g, e}) fail($sformatf("state %h exp %h", rx_state_o, e));
  endtask
  // Model is updated when the write is issued; only later reads see it.
  task automatic wb(input logic w, input int k, input logic [3:0] s, input logic [15:0] d);
    logic [15:0] bm;
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx[k], 2'b00};
    sel_i <= s;
    dat_i <= {16'($urandom), d};
    bm = {{8{s[1]}}, {8{s[0]}}} & wm[k];
    if (w) m[k] = (m[k] & ~bm) | (d & bm);
    else expq.push_back({16'h0000, m[k]});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fail("no ack");
      close_out;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (expq.size() == 0) fail("unexpected read");
      else check_dat(expq.pop_front());
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    int k;
    logic [3:0] a;
    logic [3:0] b;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 10'h000;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    m = '{`RST_CONFIG_FOUR, `RST_RGMII_CONTROL, `RST_RGMII_CONTROL_TWO,
      `RST_FAST_ETHERNET_CONFIG, 16'h0000, 16'h0000};
    void'($urandom(32'hCFDE539C));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 6; k++) wb(1'b0, k, 4'h3, 16'h0000);
    check_ports;
    for (k = 0; k < 12; k++) begin
      wb(1'b1, k % 6, 4'hF, (k < 6) ? 16'hFFFF : 16'h0000);
      wb(1'b0, k % 6, 4'h3, 16'h0000);
      check_ports;
    end
    for (k = 0; k < 30; k++) begin
      a = 4'($urandom % 6);
      wb(1'b1, a, 4'($urandom), 16'($urandom));
      wb(1'b0, a, 4'h3, 16'h0000);
      check_ports;
    end
    for (k = 0; k < 4; k++) begin
      a = 4'($urandom);
      b = 4'($urandom);
      mac_link_model_i.set_skew(a, b);
      m[4] = {8'h00, b, a};
      repeat (4) @(posedge clk_i);
      wb(1'b1, 4, 4'h3, 16'($urandom));
      wb(1'b0, 4, 4'h3, 16'h0000);
    end
    // Overlong frame and unlock, with a zero recovery field to keep the run short.
    m[3] = m[3] & 16'hF87F;
    wb(1'b1, 3, 4'h3, m[3]);
    mac_link_model_i.set_frame(1'b1);
    repeat (8) @(posedge clk_i);
    check_state(RX_FRAME, m[1][7]);
    repeat (75010) @(posedge clk_i);
    check_state(RX_RECOVER, 1'b0);
    mac_link_model_i.set_frame(1'b0);
    repeat (6) @(posedge clk_i);
    check_state(RX_IDLE, m[1][7]);
    mac_link_model_i.set_unlock(1'b1);
    repeat (6) @(posedge clk_i);
    check_state(RX_RECOVER, 1'b0);
    mac_link_model_i.set_unlock(1'b0);
    repeat (6) @(posedge clk_i);
    check_state(RX_IDLE, m[1][7]);
    repeat (2) @(posedge clk_i);
    close_out;
  end
endmodule
`default_nettype wire
